//--- inc/serial_port_pkg.sv
/*
 * Serial port constants: register indices, fields, resets, frame timing.
 * Assumes users write scoped names.
 */
package serial_port_pkg;

    // Register indices; byte address is four times the index
    localparam logic [7:0] IDX_PORT_CONTROL = 8'h80;
    localparam logic [7:0] IDX_LINE_STATUS = 8'h82;
    localparam logic [7:0] IDX_TRANSMIT_HOLDING = 8'h84;
    localparam logic [7:0] IDX_RECEIVE_BUFFER = 8'h86;
    localparam logic [7:0] IDX_BIT_RATE_DIVISOR = 8'h88;
    localparam int ADDR_W = 12;

    // Port control fields
    localparam int CTL_RX_ENABLE = 0;
    localparam int CTL_TX_ENABLE = 2;
    localparam int CTL_STOP_COUNT = 3;
    localparam int CTL_CHAR_LENGTH = 4;
    localparam int CTL_PARITY_LO = 5;
    localparam int CTL_SEND_BREAK = 8;
    localparam int CTL_LOOP_BACK = 9;
    localparam logic [15:0] CTL_RESET = 16'h0000;
    localparam logic [15:0] CTL_WRITABLE = 16'h037d;

    // Parity mode field values
    localparam logic [1:0] PAR_EVEN = 2'h2;
    localparam logic [1:0] PAR_ODD = 2'h3;

    // Line status fields
    localparam int STS_OVERRUN = 0;
    localparam int STS_PARITY = 1;
    localparam int STS_FRAMING = 2;
    localparam int STS_BREAK = 3;
    localparam int STS_RX_READY = 4;
    localparam int STS_TX_HOLD_EMPTY = 5;
    localparam int STS_TX_ALL_EMPTY = 6;

    // Other reset values
    localparam logic [15:0] DIVISOR_RESET = 16'h0000;
    localparam logic [7:0] DATA_RESET = 8'h00;

    // Oversampling: 32 ticks per bit, sampled at the centre tick
    localparam logic [4:0] TICK_MID = 5'h0f;
    localparam logic [4:0] TICK_LAST = 5'h1f;
    localparam logic [2:0] BITS_SEVEN_LAST = 3'h6;
    localparam logic [2:0] BITS_EIGHT_LAST = 3'h7;

    typedef enum logic [4:0] {
        FR_IDLE = 5'h01,
        FR_START = 5'h02,
        FR_DATA = 5'h04,
        FR_PARITY = 5'h08,
        FR_STOP = 5'h10
    } frame_state_t;

endpackage

//--- rtl/oversample_tick.sv
/*
 * One tick per period of the 32x serial clock.
 * Assumes a divisor change may stretch one period.
 */
`timescale 1ns/1ps
module oversample_tick (
    // Clock and control
    input wire logic clock_in,
    input wire logic reset_in,
    input wire logic enable_in,
    // Divisor
    input wire logic [15:0] divisor_value_in,
    // Tick
    output logic tick_out
);
    typedef struct packed {
        logic [16:0] count;
        logic tick;
    } tick_state_t;

    tick_state_t st_reg;
    tick_state_t st_next;
    logic [16:0] period;

    always_comb begin
        // Zero divisor ticks every clock
        period = (divisor_value_in == 16'h0000) ? 17'h00001 : {divisor_value_in, 1'b0}; // RL1 RL2
        st_next = st_reg;
        if (st_reg.count >= period - 17'h00001) begin
            st_next.count = 17'h00000;
            st_next.tick = 1'b1;
        end else begin
            st_next.count = st_reg.count + 17'h00001;
            st_next.tick = 1'b0;
        end
    end

    always_ff @(posedge clock_in) begin
        if (reset_in) begin
            st_reg <= '0;
        end else if (enable_in) begin
            st_reg <= st_next;
        end
    end

    assign tick_out = st_reg.tick;
endmodule

//--- rtl/frame_receiver.sv
/*
 * Receive shifter: syncs the line, finds the start, samples bit centres.
 * Assumes tick_in is one clock wide, 32 per bit.
 */
`timescale 1ns/1ps
module frame_receiver (
    // Clock and control
    input wire logic clock_in,
    input wire logic reset_in,
    input wire logic enable_in,
    input wire logic tick_in,
    input wire logic rx_enable_in,
    input wire logic char_length_in,
    input wire logic [1:0] parity_mode_in,
    // Serial line
    input wire logic line_in,
    // Finished frame
    output logic done_out,
    output logic [7:0] data_out,
    output logic parity_bad_out,
    output logic stop_bad_out,
    output logic break_out
);
    typedef struct packed {
        logic [2:0] sync;
        logic line;
        logic line_prev;
        serial_port_pkg::frame_state_t fsm;
        logic [4:0] ticks;
        logic [2:0] bit_idx;
        logic [7:0] shift;
        logic par;
        logic done;
        logic [7:0] data;
        logic parity_bad;
        logic stop_bad;
        logic brk;
    } rx_state_t;

    rx_state_t st_reg;
    rx_state_t st_next;
    logic mid;
    logic last_bit;

    always_comb begin
        st_next = st_reg;
        st_next.done = 1'b0;
        st_next.sync = {st_reg.sync[1:0], line_in};
        // Change taken once stages two and three agree
        if (st_reg.sync[1] == st_reg.sync[2]) begin
            st_next.line = st_reg.sync[2];
        end
        mid = tick_in && (st_reg.ticks == serial_port_pkg::TICK_MID);
        last_bit = st_reg.bit_idx == (char_length_in ? serial_port_pkg::BITS_EIGHT_LAST
                                                      : serial_port_pkg::BITS_SEVEN_LAST); // RL20
        if (tick_in) begin
            st_next.ticks = st_reg.ticks + 5'h01;
            st_next.line_prev = st_reg.line;
        end
        case (st_reg.fsm)
            serial_port_pkg::FR_IDLE: begin
                st_next.ticks = 5'h00;
                // Falling edge of an idle-high line opens a frame
                if (tick_in && rx_enable_in && st_reg.line_prev && !st_reg.line) begin // RL18 RL22 RL23
                    st_next.fsm = serial_port_pkg::FR_START;
                    st_next.ticks = 5'h01;
                    st_next.bit_idx = 3'h0;
                    st_next.shift = 8'h00;
                    st_next.par = 1'b0;
                end
            end
            serial_port_pkg::FR_START: begin
                // A low pulse shorter than half a bit is taken as noise
                if (mid && st_reg.line) begin // RL23
                    st_next.fsm = serial_port_pkg::FR_IDLE;
                end else if (tick_in && st_reg.ticks == serial_port_pkg::TICK_LAST) begin
                    st_next.fsm = serial_port_pkg::FR_DATA;
                end
            end
            serial_port_pkg::FR_DATA: begin
                if (mid) begin
                    st_next.shift[st_reg.bit_idx] = st_reg.line; // RL5 RL22
                    st_next.par = st_reg.par ^ st_reg.line;
                end
                if (tick_in && st_reg.ticks == serial_port_pkg::TICK_LAST) begin
                    st_next.bit_idx = st_reg.bit_idx + 3'h1;
                    if (last_bit) begin
                        st_next.fsm = parity_mode_in[1] ? serial_port_pkg::FR_PARITY
                                                        : serial_port_pkg::FR_STOP;
                    end
                end
            end
            serial_port_pkg::FR_PARITY: begin
                if (mid) begin
                    st_next.par = st_reg.par ^ st_reg.line;
                end
                if (tick_in && st_reg.ticks == serial_port_pkg::TICK_LAST) begin
                    st_next.fsm = serial_port_pkg::FR_STOP;
                end
            end
            serial_port_pkg::FR_STOP: begin
                // Report at the stop centre so the next start edge is not missed
                if (mid) begin
                    st_next.fsm = serial_port_pkg::FR_IDLE;
                    st_next.done = 1'b1;
                    st_next.data = st_reg.shift;
                    st_next.stop_bad = !st_reg.line; // RL13
                    st_next.parity_bad = (parity_mode_in == serial_port_pkg::PAR_EVEN && st_reg.par)
                        || (parity_mode_in == serial_port_pkg::PAR_ODD && !st_reg.par); // RL14
                    st_next.brk = !st_reg.line && (st_reg.shift == 8'h00)
                        && !(parity_mode_in[1] && st_reg.par); // RL12
                end
            end
            default: begin
                st_next.fsm = serial_port_pkg::FR_IDLE;
            end
        endcase
    end

    always_ff @(posedge clock_in) begin
        if (reset_in) begin
            st_reg <= '0;
            st_reg.sync <= 3'h7;
            st_reg.line <= 1'b1;
            st_reg.line_prev <= 1'b1;
            st_reg.fsm <= serial_port_pkg::FR_IDLE;
        end else if (enable_in) begin
            st_reg <= st_next;
        end
    end

    assign done_out = st_reg.done;
    assign data_out = st_reg.data;
    assign parity_bad_out = st_reg.parity_bad;
    assign stop_bad_out = st_reg.stop_bad;
    assign break_out = st_reg.brk;
endmodule

//--- rtl/serial_port.sv
/*
 * Serial port behind APB: control, status, double-buffered transmitter,
 * receive buffer, divisor. Assumes one clock shared with APB; rxd is a pin.
 */
// Our own choice: register access over APB.
// Function
// RL1: Divisor counts clocks per half-period of the 32x clock.
// RL2: Divisor zero gives one thirty-second of the clock rate.
// RL3: Divisor register is sixteen bits, reset value undefined.
// RL4: Software reloads the divisor when the clock changes.
// RL5: Characters assemble in a hidden shifter, then move to the buffer.
// RL6: Receive buffer bits 7..0, valid while rx_ready.
// RL7: Holding register feeds a hidden transmit shifter.
// RL8: Software checks tx_holding_empty before writing the holding register.
// RL9: Status bit 6: holding and shift registers both empty.
// RL10: Status bit 5: holding register can take a character.
// RL11: Status bit 4: valid receive data; only a buffer read clears it.
// RL12: Status bit 3: break received; requests an interrupt.
// RL13: Status bit 2: stop bit sampled low.
// RL14: Status bit 1: parity error in parity modes.
// RL15: Status bit 0: new character overwrote an unread one.
// RL16: Status reset value undefined; reserved bits carry nothing.
// RL17: Port control resets to zero.
// RL18: Control bit 0 enables the receiver.
// RL19: Control bit 2 enables the transmitter.
// RL20: Control bit 4 selects eight data bits, else seven.
// RL21: Control bit 3 selects two stop bits, else one.
// RL22: Line idles high; low start, data LSB first, high stops.
// RL23: Receiver finds the start edge and samples bit centres.
`timescale 1ns/1ps
module serial_port (
    // Clock, reset, clock enable
    input wire logic clock_in,
    input wire logic reset_in,
    input wire logic clock_enable_in,
    // APB slave
    input wire logic psel_in,
    input wire logic penable_in,
    input wire logic pwrite_in,
    input wire logic [serial_port_pkg::ADDR_W-1:0] paddr_in,
    input wire logic [31:0] pwdata_in,
    output logic [31:0] prdata_out,
    output logic pready_out,
    output logic pslverr_out,
    // Serial line
    input wire logic rxd_in,
    output logic txd_out,
    // Break interrupt request
    output logic break_irq_out
);
    typedef struct packed {
        logic [15:0] control;
        logic [15:0] divisor;
        logic [7:0] rx_buffer;
        logic rx_ready;
        logic brk_seen;
        logic frm_err;
        logic par_err;
        logic ovr_err;
        logic [7:0] hold_data;
        logic hold_full;
        serial_port_pkg::frame_state_t tx_fsm;
        logic [4:0] tx_ticks;
        logic [2:0] tx_bit;
        logic [7:0] tx_shift;
        logic tx_par;
        logic tx_stop2;
        logic txd;
        logic [31:0] prdata;
        logic pready;
        logic pslverr;
    } port_state_t;

    localparam int ADDR_HI = serial_port_pkg::ADDR_W - 1;

    port_state_t st_reg;
    port_state_t st_next;

    logic tick;
    logic rx_done;
    logic [7:0] rx_data;
    logic rx_parity_bad;
    logic rx_stop_bad;
    logic rx_break;
    logic rx_line;
    logic setup_phase;
    logic access_done;
    logic [7:0] reg_idx;
    logic addr_ok;
    logic [15:0] status_word;
    logic [15:0] read_word;
    logic tx_end_bit;
    logic tx_last_data;

    oversample_tick u_tick (
        .clock_in(clock_in),
        .reset_in(reset_in),
        .enable_in(clock_enable_in),
        .divisor_value_in(st_reg.divisor),
        .tick_out(tick)
    );

    // Loop-back feeds txd into the receiver
    assign rx_line = st_reg.control[serial_port_pkg::CTL_LOOP_BACK] ? st_reg.txd : rxd_in;

    frame_receiver u_rx (
        .clock_in(clock_in),
        .reset_in(reset_in),
        .enable_in(clock_enable_in),
        .tick_in(tick),
        .rx_enable_in(st_reg.control[serial_port_pkg::CTL_RX_ENABLE]),
        .char_length_in(st_reg.control[serial_port_pkg::CTL_CHAR_LENGTH]),
        .parity_mode_in(st_reg.control[serial_port_pkg::CTL_PARITY_LO +: 2]),
        .line_in(rx_line),
        .done_out(rx_done),
        .data_out(rx_data),
        .parity_bad_out(rx_parity_bad),
        .stop_bad_out(rx_stop_bad),
        .break_out(rx_break)
    );

    always_comb begin
        st_next = st_reg;
        setup_phase = psel_in && !penable_in;
        access_done = psel_in && penable_in && st_reg.pready;
        reg_idx = paddr_in[9:2];
        addr_ok = (paddr_in[1:0] == 2'h0) && (paddr_in[ADDR_HI:10] == '0)
            && (reg_idx inside {serial_port_pkg::IDX_PORT_CONTROL, serial_port_pkg::IDX_LINE_STATUS,
            serial_port_pkg::IDX_TRANSMIT_HOLDING, serial_port_pkg::IDX_RECEIVE_BUFFER,
            serial_port_pkg::IDX_BIT_RATE_DIVISOR});

        status_word = 16'h0000; // RL16
        status_word[serial_port_pkg::STS_TX_ALL_EMPTY] = !st_reg.hold_full
            && (st_reg.tx_fsm == serial_port_pkg::FR_IDLE); // RL9
        status_word[serial_port_pkg::STS_TX_HOLD_EMPTY] = !st_reg.hold_full; // RL10
        status_word[serial_port_pkg::STS_RX_READY] = st_reg.rx_ready;
        status_word[serial_port_pkg::STS_BREAK] = st_reg.brk_seen;
        status_word[serial_port_pkg::STS_FRAMING] = st_reg.frm_err;
        status_word[serial_port_pkg::STS_PARITY] = st_reg.par_err;
        status_word[serial_port_pkg::STS_OVERRUN] = st_reg.ovr_err;

        case (reg_idx)
            serial_port_pkg::IDX_PORT_CONTROL: read_word = st_reg.control;
            serial_port_pkg::IDX_LINE_STATUS: read_word = status_word;
            serial_port_pkg::IDX_TRANSMIT_HOLDING: read_word = {8'h00, st_reg.hold_data};
            serial_port_pkg::IDX_RECEIVE_BUFFER: read_word = {8'h00, st_reg.rx_buffer}; // RL6
            serial_port_pkg::IDX_BIT_RATE_DIVISOR: read_word = st_reg.divisor;
            default: read_word = 16'h0000;
        endcase

        // Zero wait states; answer comes from flops
        st_next.pready = setup_phase;
        if (setup_phase) begin
            st_next.prdata = (addr_ok && !pwrite_in) ? {16'h0000, read_word} : 32'h00000000;
            st_next.pslverr = !addr_ok;
        end else begin
            st_next.pslverr = 1'b0;
        end

        // Writes and read-clear act at the completing edge
        if (access_done && addr_ok && pwrite_in) begin
            case (reg_idx)
                serial_port_pkg::IDX_PORT_CONTROL: begin
                    st_next.control = pwdata_in[15:0] & serial_port_pkg::CTL_WRITABLE;
                end
                serial_port_pkg::IDX_LINE_STATUS: begin
                    // Writing zero clears an error flag; rx_ready ignores writes
                    st_next.brk_seen = st_reg.brk_seen & pwdata_in[serial_port_pkg::STS_BREAK]; // RL12
                    st_next.frm_err = st_reg.frm_err & pwdata_in[serial_port_pkg::STS_FRAMING]; // RL13
                    st_next.par_err = st_reg.par_err & pwdata_in[serial_port_pkg::STS_PARITY]; // RL14
                    st_next.ovr_err = st_reg.ovr_err & pwdata_in[serial_port_pkg::STS_OVERRUN]; // RL15
                end
                serial_port_pkg::IDX_TRANSMIT_HOLDING: begin
                    st_next.hold_data = pwdata_in[7:0]; // RL7
                    st_next.hold_full = 1'b1;
                end
                serial_port_pkg::IDX_BIT_RATE_DIVISOR: begin
                    st_next.divisor = pwdata_in[15:0]; // RL3
                end
                default: begin
                    st_next.divisor = st_reg.divisor;
                end
            endcase
        end
        if (access_done && addr_ok && !pwrite_in && reg_idx == serial_port_pkg::IDX_RECEIVE_BUFFER) begin
            st_next.rx_ready = 1'b0; // RL11
        end

        // Hardware set wins over a same-cycle clear
        if (rx_done) begin
            st_next.rx_buffer = rx_data; // RL5
            st_next.rx_ready = 1'b1; // RL11
            if (st_reg.rx_ready) begin
                st_next.ovr_err = 1'b1; // RL15
            end
            if (rx_stop_bad) begin
                st_next.frm_err = 1'b1; // RL13
            end
            if (rx_parity_bad) begin
                st_next.par_err = 1'b1; // RL14
            end
            if (rx_break) begin
                st_next.brk_seen = 1'b1; // RL12
            end
        end

        // Transmit shifter
        tx_end_bit = tick && (st_reg.tx_ticks == serial_port_pkg::TICK_LAST);
        tx_last_data = st_reg.tx_bit == (st_reg.control[serial_port_pkg::CTL_CHAR_LENGTH]
            ? serial_port_pkg::BITS_EIGHT_LAST : serial_port_pkg::BITS_SEVEN_LAST); // RL20
        if (tick) begin
            st_next.tx_ticks = st_reg.tx_ticks + 5'h01;
        end
        case (st_reg.tx_fsm)
            serial_port_pkg::FR_IDLE: begin
                st_next.txd = 1'b1;
                // Loading the shifter frees the holding register
                if (tick && st_reg.hold_full && st_reg.control[serial_port_pkg::CTL_TX_ENABLE]) begin // RL19 RL7
                    st_next.tx_shift = st_reg.hold_data;
                    st_next.hold_full = st_next.hold_full && access_done && pwrite_in
                        && reg_idx == serial_port_pkg::IDX_TRANSMIT_HOLDING;
                    st_next.tx_fsm = serial_port_pkg::FR_START;
                    st_next.tx_ticks = 5'h00;
                    st_next.tx_bit = 3'h0;
                    st_next.tx_par = 1'b0;
                    st_next.txd = 1'b0; // RL22
                end
            end
            serial_port_pkg::FR_START: begin
                if (tx_end_bit) begin
                    st_next.tx_fsm = serial_port_pkg::FR_DATA;
                    st_next.txd = st_reg.tx_shift[0]; // RL22
                end
            end
            serial_port_pkg::FR_DATA: begin
                if (tx_end_bit) begin
                    st_next.tx_par = st_reg.tx_par ^ st_reg.txd;
                    st_next.tx_bit = st_reg.tx_bit + 3'h1;
                    st_next.txd = st_reg.tx_shift[st_reg.tx_bit + 3'h1];
                    if (tx_last_data) begin
                        st_next.tx_stop2 = st_reg.control[serial_port_pkg::CTL_STOP_COUNT]; // RL21
                        if (st_reg.control[serial_port_pkg::CTL_PARITY_LO + 1]) begin
                            st_next.tx_fsm = serial_port_pkg::FR_PARITY;
                            st_next.txd = st_reg.tx_par ^ st_reg.txd
                                ^ st_reg.control[serial_port_pkg::CTL_PARITY_LO];
                        end else begin
                            st_next.tx_fsm = serial_port_pkg::FR_STOP;
                            st_next.txd = 1'b1;
                        end
                    end
                end
            end
            serial_port_pkg::FR_PARITY: begin
                if (tx_end_bit) begin
                    st_next.tx_fsm = serial_port_pkg::FR_STOP;
                    st_next.txd = 1'b1;
                end
            end
            serial_port_pkg::FR_STOP: begin
                if (tx_end_bit) begin
                    if (st_reg.tx_stop2) begin
                        st_next.tx_stop2 = 1'b0; // RL21
                    end else begin
                        st_next.tx_fsm = serial_port_pkg::FR_IDLE;
                    end
                end
            end
            default: begin
                st_next.tx_fsm = serial_port_pkg::FR_IDLE;
                st_next.txd = 1'b1;
            end
        endcase
        // Send-break forces the line low over any frame in flight
        if (st_next.control[serial_port_pkg::CTL_SEND_BREAK]) begin
            st_next.txd = 1'b0;
        end
    end

    always_ff @(posedge clock_in) begin
        if (reset_in) begin
            st_reg <= '0;
            st_reg.control <= serial_port_pkg::CTL_RESET; // RL17
            st_reg.divisor <= serial_port_pkg::DIVISOR_RESET;
            st_reg.rx_buffer <= serial_port_pkg::DATA_RESET;
            st_reg.hold_data <= serial_port_pkg::DATA_RESET;
            st_reg.tx_fsm <= serial_port_pkg::FR_IDLE;
            st_reg.txd <= 1'b1;
        end else if (clock_enable_in) begin
            st_reg <= st_next;
        end
    end

    assign prdata_out = st_reg.prdata;
    assign pready_out = st_reg.pready;
    assign pslverr_out = st_reg.pslverr;
    assign txd_out = st_reg.txd;
    assign break_irq_out = st_reg.brk_seen; // RL12
endmodule

//--- bench/serial_port_sva.sv
/* Checker on serial_port ports.
   Assumes one clock, bound to the top module. */
`timescale 1ns/1ps
module serial_port_sva (
    // Clock and APB
    input wire logic clock_in,
    input wire logic reset_in,
    input wire logic clock_enable_in,
    input wire logic psel_in,
    input wire logic penable_in,
    input wire logic pwrite_in,
    input wire logic [serial_port_pkg::ADDR_W-1:0] paddr_in,
    input wire logic [31:0] prdata_out,
    input wire logic pready_out,
    input wire logic pslverr_out,
    // Serial
    input wire logic txd_out,
    input wire logic break_irq_out
);
    default clocking cb @(posedge clock_in);
    endclocking
    default disable iff (reset_in);
    logic mapped;
    assign mapped = paddr_in inside {12'h200, 12'h208, 12'h210, 12'h218, 12'h220};
    sequence setup_s;
        psel_in && !penable_in && clock_enable_in;
    endsequence
    sequence read_s(a);
        setup_s ##0 (!pwrite_in && paddr_in == a);
    endsequence
    apb_answer_a: assert property (setup_s |=> pready_out) else $error("no answer");
    ready_pulse_a: assert property (pready_out |=> !pready_out) else $error("ready held");
    bad_addr_a: assert property (setup_s ##0 !mapped |=> pslverr_out && prdata_out == 32'h0) else $error("bad decode");
    good_addr_a: assert property (setup_s ##0 mapped |=> !pslverr_out) else $error("false error");
    status_resv_a: assert property (read_s(12'h208) |=> prdata_out[31:7] == 25'h0) else $error("status");
    rx_resv_a: assert property (read_s(12'h218) |=> prdata_out[31:8] == 24'h0) else $error("rx data");
    irq_status_a: assert property (read_s(12'h208) |=> prdata_out[3] == $past(break_irq_out)) else $error("irq");
    txd_idle_a: assert property (disable iff (1'b0) reset_in && clock_enable_in |=> txd_out) else $error("txd");
endmodule

bind serial_port serial_port_sva chk (.clock_in, .reset_in, .clock_enable_in, .psel_in, .penable_in, .pwrite_in,
    .paddr_in, .prdata_out, .pready_out, .pslverr_out, .txd_out, .break_irq_out);

//--- bench/remote_serial.sv
/* Far-end serial device: sends frames, reports those heard.
   Assumes the bit time in clocks. */
`timescale 1ns/1ps
module remote_serial (
    // Clock and bit time
    input wire logic clock_in,
    input wire logic [15:0] bit_cycles_in,
    // Lines
    input wire logic txd_in,
    output logic rxd_out = 1'b1,
    // One pulse per heard character
    output logic got_out = 1'b0,
    output logic [7:0] got_data_out = 8'h00
);
    // A low stop bit makes a framing fault on purpose
    task automatic send(input logic [7:0] d, input logic stop);
        for (int i = 0; i < 10; i++) begin
            rxd_out <= (i == 0) ? 1'b0 : (i == 9) ? stop : d[i-1];
            repeat (bit_cycles_in) @(posedge clock_in);
        end
        rxd_out <= 1'b1;
        @(posedge clock_in);
    endtask
    always begin
        @(negedge txd_in);
        repeat (bit_cycles_in / 2) @(posedge clock_in);
        for (int i = 0; i < 8; i++) begin
            repeat (bit_cycles_in) @(posedge clock_in);
            got_data_out[i] = txd_in;
        end
        got_out <= 1'b1;
        @(posedge clock_in);
        got_out <= 1'b0;
    end
endmodule

//--- bench/serial_port_tb.sv
/* Bench for serial_port: APB tasks, far-end model, queued checks.
   Assumes a 4 ns clock. */
`timescale 1ns/1ps
module serial_port_tb;
    logic clock_in, reset_in = 1'b1, psel_in = 1'b0, penable_in = 1'b0, pwrite_in = 1'b0;
    logic pready_out, pslverr_out, rxd, txd, irq, got;
    logic [11:0] paddr_in = 12'h0;
    logic [31:0] pwdata_in = 32'h0, prdata_out, q, rnd = 32'h148ec;
    logic [15:0] bitc = 16'h20;
    logic [7:0] got_data;
    logic [63:0] e, expq[$];
    logic [7:0] txq[$];
    int errors, checks;
    serial_port DUT (.clock_in, .reset_in, .clock_enable_in(1'b1), .psel_in, .penable_in, .pwrite_in, .paddr_in,
        .pwdata_in, .prdata_out, .pready_out, .pslverr_out, .rxd_in(rxd), .txd_out(txd), .break_irq_out(irq));
    remote_serial far (.clock_in, .bit_cycles_in(bitc), .txd_in(txd), .rxd_out(rxd), .got_out(got),
        .got_data_out(got_data));
    function automatic logic [31:0] xs(input logic [31:0] s);
        s = s ^ (s << 13);
        s = s ^ (s >> 17);
        return s ^ (s << 5);
    endfunction
    task automatic close_out;
        $display("errors %0d checks %0d", errors, checks);
        if (errors == 0 && checks > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask
    task automatic cmp(input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            errors++;
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    // Mask zero: not compared
    task automatic apb(input logic [11:0] a, input logic wr, input logic [31:0] d, input logic [31:0] m);
        int n;
        expq.push_back({m, d});
        psel_in <= 1'b1;
        pwrite_in <= wr;
        paddr_in <= a;
        pwdata_in <= d;
        @(posedge clock_in);
        penable_in <= 1'b1;
        n = 0;
        do begin
            @(posedge clock_in);
            n++;
        end while (pready_out !== 1'b1 && n < 50);
        if (n >= 50) errors++;
        if (n >= 50) close_out();
        q = prdata_out;
        psel_in <= 1'b0;
        penable_in <= 1'b0;
        @(posedge clock_in);
    endtask
    task automatic poll(input int b, input logic v);
        int n;
        n = 0;
        do begin
            apb(12'h208, 1'b0, 32'h0, 32'h0);
            n++;
        end while (q[b] !== v && n < 4000);
        if (n >= 4000) errors++;
        if (n >= 4000) close_out();
    endtask
    always @(posedge clock_in) begin
        if (pready_out === 1'b1 && expq.size() > 0) begin
            e = expq.pop_front();
            if (e[63:32] != 32'h0) cmp(prdata_out & e[63:32], e[31:0]);
        end
        if (got === 1'b1) cmp({24'h0, got_data}, {24'h0, txq.pop_front()});
    end
    initial begin
        clock_in = 1'b0;
        forever #2 clock_in = ~clock_in;
    end
    initial begin
        repeat (6) @(posedge clock_in);
        reset_in <= 1'b0;
        apb(12'h200, 1'b0, 32'h0, 32'hffff);
        apb(12'h208, 1'b0, 32'h60, 32'hffff);
        apb(12'h204, 1'b0, 32'h0, 32'hffffffff);
        for (int dv = 0; dv < 2; dv++) begin
            bitc <= dv ? 16'h40 : 16'h20;
            apb(12'h220, 1'b1, 32'(dv), 32'h0);
            apb(12'h220, 1'b0, 32'(dv), 32'hffff);
            apb(12'h200, 1'b1, 32'h15, 32'h0);
            for (int k = 0; k < 3; k++) begin
                poll(5, 1'b1);
                rnd = xs(rnd);
                txq.push_back(rnd[7:0]);
                apb(12'h210, 1'b1, {24'h0, rnd[7:0]}, 32'h0);
            end
            poll(6, 1'b1);
            far.send(rnd[15:8], 1'b1);
            poll(4, 1'b1);
            apb(12'h218, 1'b0, {24'h0, rnd[15:8]}, 32'hffff);
            apb(12'h208, 1'b0, 32'h60, 32'hffff);
        end
        far.send(8'h5a, 1'b1);
        far.send(8'ha5, 1'b1);
        apb(12'h208, 1'b0, 32'h71, 32'hffff);
        apb(12'h218, 1'b0, 32'ha5, 32'hffff);
        apb(12'h208, 1'b1, 32'h0, 32'h0);
        far.send(8'h81, 1'b0);
        apb(12'h208, 1'b0, 32'h04, 32'h0f);
        apb(12'h208, 1'b1, 32'h0, 32'h0);
        apb(12'h218, 1'b0, 32'h0, 32'h0);
        far.send(8'h00, 1'b0);
        apb(12'h208, 1'b0, 32'h0c, 32'h0f);
        cmp({31'h0, irq}, 32'h1);
        apb(12'h200, 1'b1, 32'h05, 32'h0);
        apb(12'h218, 1'b0, 32'h0, 32'h0);
        far.send(8'hff, 1'b1);
        poll(4, 1'b1);
        apb(12'h218, 1'b0, 32'h7f, 32'hffff);
        apb(12'h208, 1'b1, 32'h0, 32'h0);
        apb(12'h200, 1'b1, 32'h45, 32'h0);
        far.send(8'h01, 1'b1);
        apb(12'h208, 1'b0, 32'h02, 32'h0f);
        apb(12'h218, 1'b0, 32'h01, 32'hffff);
        apb(12'h200, 1'b1, 32'h25d, 32'h0);
        txq.push_back({1'b0, rnd[22:16]});
        apb(12'h210, 1'b1, {25'h0, rnd[22:16]}, 32'h0);
        poll(4, 1'b1);
        apb(12'h218, 1'b0, {25'h0, rnd[22:16]}, 32'hffff);
        close_out();
    end
endmodule
